// *** rtl/bsm_exec_unit.sv ***
// Bit, shift and move execution unit with its AXI4-Lite register slave
//
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// ************************************************************
// ************************************************************
module bsm_exec_unit (
    // Clock, reset and clock enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [bsm_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [bsm_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [bsm_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [bsm_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Execution status
    output logic busy,
    output logic done
);
    import bsm_pkg::*;

    // ************************************************************
    // Memories
    // ************************************************************
    bsm_gpr_if gp ();
    bsm_dm_if dm ();

    bsm_gpr u_gpr (.clk(clk), .rst(rst), .ce(ce), .gp(gp));
    bsm_dmem u_dmem (.clk(clk), .rst(rst), .ce(ce), .dm(dm));

    // ************************************************************
    // State
    // ************************************************************
    logic aw_q, aw_d, w_q, w_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [ADDR_W-1:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d, wmask, rd_word;
    logic [3:0] wstrb_q, wstrb_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] cmd_q, cmd_d;
    logic [7:0] imm_q, imm_d, status_flags_register_q, status_flags_register_d, res_q, res_d, iotmp_q, iotmp_d;
    logic [15:0] x_q, x_d;
    logic [7:0] io_q [IO_NUM];
    logic [7:0] io_d [IO_NUM];
    bsm_state_e state_q, state_d;
    logic done_q, done_d;
    logic wr_fire, wr_map, wr_ok, io_wsel, rd_map, two_cyc, shift, gwe, cout;
    logic [7:0] res8, sh;
    bsm_op_e op;
    logic [4:0] rd, rr;
    logic [2:0] bsel, iosel;

    assign op = bsm_op_e'(cmd_q[CMD_OP_LSB +: 5]);
    assign rd = cmd_q[CMD_RD_LSB +: 5];
    assign rr = cmd_q[CMD_RR_LSB +: 5];
    assign bsel = cmd_q[CMD_BIT_LSB +: 3];
    assign iosel = rr[2:0];
    assign two_cyc = op inside {OP_IO_SET, OP_IO_CLR, OP_LD_X, OP_LD_XINC, OP_LD_XDEC};
    assign busy = (state_q != ST_IDLE);
    assign done = done_q;

    // Copies read the source, everything else reads the destination
    assign gp.raddr_a = (op == OP_MOV || op == OP_REGISTER_PAIR_COPY) ? rr : rd;
    assign gp.raddr_b = {rr[4:1], 1'b1};

    // ************************************************************
    // AXI4-Lite slave
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_mask
            assign wmask[gi*8 +: 8] = {8{wstrb_q[gi]}};
        end
    endgenerate

    assign io_wsel = (awaddr_q[7:5] == OFF_IO[7:5]);
    assign wr_map = io_wsel || awaddr_q[7:2] inside {OFF_CMD[7:2], OFF_OPND[7:2],
        OFF_FLAGS[7:2], OFF_XPTR[7:2], OFF_DMWR[7:2]};
    // Writes during a running instruction are refused so operands stay stable
    assign wr_ok = wr_map && !busy;
    assign wr_fire = aw_q && w_q && !bvalid_q;

    // Handshakes are gated by the clock enable; keep ce high during bus traffic
    assign s_axi_awready = ce && !aw_q && !bvalid_q;
    assign s_axi_wready = ce && !w_q && !bvalid_q;
    assign s_axi_arready = ce && !rvalid_q;
    assign s_axi_bvalid = ce && bvalid_q;
    assign s_axi_rvalid = ce && rvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always_comb begin
        rd_word = '0;
        rd_map = 1'b1;
        if (s_axi_araddr[7:5] == OFF_IO[7:5]) begin
            rd_word[7:0] = io_q[s_axi_araddr[4:2]];
        end else begin
            case (s_axi_araddr[7:2])
                OFF_CMD[7:2]: rd_word = cmd_q;
                OFF_OPND[7:2]: rd_word[7:0] = imm_q;
                OFF_STAT[7:2]: begin
                    rd_word[7:0] = status_flags_register_q;
                    rd_word[STAT_BUSY] = busy;
                end
                OFF_FLAGS[7:2]: rd_word[7:0] = status_flags_register_q;
                OFF_XPTR[7:2]: rd_word[15:0] = x_q;
                OFF_RES[7:2]: rd_word[7:0] = res_q;
                OFF_DMWR[7:2]: rd_word = '0;
                default: rd_map = 1'b0;
            endcase
        end
    end

    always_comb begin
        aw_d = aw_q;
        awaddr_d = awaddr_q;
        w_d = w_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (wr_fire) begin
            aw_d = 1'b0;
            w_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rdata_d = rd_word;
            rresp_d = rd_map ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_q <= 1'b0;
            awaddr_q <= '0;
            w_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (ce) begin
            aw_q <= aw_d;
            awaddr_q <= awaddr_d;
            w_q <= w_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    // ************************************************************
    // Execution
    // ************************************************************
    always_comb begin
        state_d = state_q;
        cmd_d = cmd_q;
        imm_d = imm_q;
        status_flags_register_d = status_flags_register_q;
        x_d = x_q;
        res_d = res_q;
        iotmp_d = iotmp_q;
        done_d = 1'b0;
        for (int i = 0; i < IO_NUM; i++) begin
            io_d[i] = io_q[i];
        end
        gp.we = 1'b0;
        gp.we_pair = 1'b0;
        gp.waddr = rd;
        gp.wdata = 16'h0000;
        dm.we = 1'b0;
        dm.addr = x_q[DM_AW-1:0];
        dm.wdata = wdata_q[7:0];
        res8 = 8'h00;
        sh = 8'h00;
        cout = 1'b0;
        shift = 1'b0;
        gwe = 1'b0;

        // Software writes, taken only while idle
        if (wr_fire && wr_ok) begin
            if (io_wsel) begin
                io_d[awaddr_q[4:2]] = (io_q[awaddr_q[4:2]] & ~wmask[7:0]) | (wdata_q[7:0] & wmask[7:0]);
            end else begin
                case (awaddr_q[7:2])
                    OFF_CMD[7:2]: begin
                        cmd_d = (cmd_q & ~wmask) | (wdata_q & wmask);
                        state_d = ST_FETCH;
                    end
                    OFF_OPND[7:2]: imm_d = (imm_q & ~wmask[7:0]) | (wdata_q[7:0] & wmask[7:0]);
                    OFF_FLAGS[7:2]: status_flags_register_d = (status_flags_register_q & ~wmask[7:0]) | (wdata_q[7:0] & wmask[7:0]);
                    OFF_XPTR[7:2]: x_d = (x_q & ~wmask[15:0]) | (wdata_q[15:0] & wmask[15:0]);
                    OFF_DMWR[7:2]: begin
                        dm.we = 1'b1;
                        dm.addr = wdata_q[DMWR_ADDR_LSB +: DM_AW];
                    end
                    default: ;
                endcase
            end
        end

        case (state_q)
            ST_IDLE: ;
            // Register file read is registered, so one cycle fetches operands
            ST_FETCH: state_d = ST_EX1;
            ST_EX1: begin
                state_d = two_cyc ? ST_EX2 : ST_IDLE;
                done_d = !two_cyc;
                case (op)
                    OP_IO_SET, OP_IO_CLR: begin
                        iotmp_d = io_q[iosel];
                        iotmp_d[bsel] = (op == OP_IO_SET);
                    end
                    OP_LSL: begin
                        sh = {gp.rdata_a[6:0], 1'b0};
                        cout = gp.rdata_a[7];
                        shift = 1'b1;
                    end
                    OP_LSR: begin
                        sh = {1'b0, gp.rdata_a[7:1]};
                        cout = gp.rdata_a[0];
                        shift = 1'b1;
                    end
                    OP_ROL: begin
                        sh = {gp.rdata_a[6:0], status_flags_register_q[FLG_C]};
                        cout = gp.rdata_a[7];
                        shift = 1'b1;
                    end
                    OP_ROR: begin
                        sh = {status_flags_register_q[FLG_C], gp.rdata_a[7:1]};
                        cout = gp.rdata_a[0];
                        shift = 1'b1;
                    end
                    OP_ASR: begin
                        sh = {gp.rdata_a[7], gp.rdata_a[7:1]};
                        cout = gp.rdata_a[0];
                        shift = 1'b1;
                    end
                    OP_SWAP: begin
                        res8 = {gp.rdata_a[3:0], gp.rdata_a[7:4]};
                        gwe = 1'b1;
                    end
                    OP_FLAG_SET: status_flags_register_d[bsel] = 1'b1;
                    OP_FLAG_CLR: status_flags_register_d[bsel] = 1'b0;
                    OP_BST: status_flags_register_d[FLG_T] = gp.rdata_a[bsel];
                    OP_BLD: begin
                        res8 = gp.rdata_a;
                        res8[bsel] = status_flags_register_q[FLG_T];
                        gwe = 1'b1;
                    end
                    OP_MOV, OP_LDI: begin
                        res8 = (op == OP_LDI) ? imm_q : gp.rdata_a;
                        gwe = 1'b1;
                    end
                    OP_REGISTER_PAIR_COPY: begin
                        gp.we = 1'b1;
                        gp.we_pair = 1'b1;
                        gp.wdata = {gp.rdata_b, gp.rdata_a};
                        res_d = gp.rdata_a;
                    end
                    OP_LD_XDEC: begin
                        x_d = x_q - 16'h0001;
                        dm.addr = x_d[DM_AW-1:0];
                    end
                    OP_IRQ_ON: status_flags_register_d[FLG_I] = 1'b1;
                    OP_IRQ_OFF: status_flags_register_d[FLG_I] = 1'b0;
                    default: ;
                endcase
                if (shift) begin
                    res8 = sh;
                    gwe = 1'b1;
                    status_flags_register_d[FLG_C] = cout;
                    status_flags_register_d[FLG_Z] = (sh == 8'h00);
                    status_flags_register_d[FLG_N] = sh[7];
                    status_flags_register_d[FLG_V] = sh[7] ^ cout;
                end
            end
            ST_EX2: begin
                state_d = ST_IDLE;
                done_d = 1'b1;
                if (op == OP_IO_SET || op == OP_IO_CLR) begin
                    io_d[iosel] = iotmp_q;
                end else begin
                    res8 = dm.rdata;
                    gwe = 1'b1;
                    if (op == OP_LD_XINC) begin
                        x_d = x_q + 16'h0001;
                    end
                end
            end
            default: state_d = ST_IDLE;
        endcase

        if (gwe) begin
            gp.we = 1'b1;
            gp.wdata = {8'h00, res8};
            res_d = res8;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            cmd_q <= CMD_RST;
            imm_q <= BYTE_RST;
            status_flags_register_q <= BYTE_RST;
            x_q <= XPTR_RST;
            res_q <= BYTE_RST;
            iotmp_q <= BYTE_RST;
            done_q <= 1'b0;
            for (int i = 0; i < IO_NUM; i++) begin
                io_q[i] <= BYTE_RST;
            end
        end else if (ce) begin
            state_q <= state_d;
            cmd_q <= cmd_d;
            imm_q <= imm_d;
            status_flags_register_q <= status_flags_register_d;
            x_q <= x_d;
            res_q <= res_d;
            iotmp_q <= iotmp_d;
            done_q <= done_d;
            for (int i = 0; i < IO_NUM; i++) begin
                io_q[i] <= io_d[i];
            end
        end
    end
endmodule

// *** rtl/bsm_pkg.sv ***
// Constants and types shared by the bit, shift and move execution unit
package bsm_pkg;
    // ************************************************************
    // Bus and storage sizes
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int IO_NUM = 8;
    localparam int GPR_NUM = 32;
    localparam int DM_AW = 8;
    localparam int DM_DEPTH = 256;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_OPND = 8'h04;
    localparam logic [7:0] OFF_STAT = 8'h08;
    localparam logic [7:0] OFF_FLAGS = 8'h0c;
    localparam logic [7:0] OFF_XPTR = 8'h10;
    localparam logic [7:0] OFF_RES = 8'h14;
    localparam logic [7:0] OFF_DMWR = 8'h18;
    localparam logic [7:0] OFF_IO = 8'h20;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_RD_LSB = 8;
    localparam int CMD_RR_LSB = 16;
    localparam int CMD_BIT_LSB = 24;
    localparam int DMWR_ADDR_LSB = 8;
    localparam int STAT_BUSY = 8;
    localparam logic [31:0] CMD_RST = 32'h0000_0000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [15:0] XPTR_RST = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Status flag bit positions
    localparam int FLG_C = 0;
    localparam int FLG_Z = 1;
    localparam int FLG_N = 2;
    localparam int FLG_V = 3;
    localparam int FLG_S = 4;
    localparam int FLG_H = 5;
    localparam int FLG_T = 6;
    localparam int FLG_I = 7;

    // ************************************************************
    // Operations and states
    // ************************************************************
    typedef enum logic [4:0] {
        OP_NOP = 5'h00, OP_IO_SET = 5'h01, OP_IO_CLR = 5'h02, OP_LSL = 5'h03,
        OP_LSR = 5'h04, OP_ROL = 5'h05, OP_ROR = 5'h06, OP_ASR = 5'h07,
        OP_SWAP = 5'h08, OP_FLAG_SET = 5'h09, OP_FLAG_CLR = 5'h0a, OP_BST = 5'h0b,
        OP_BLD = 5'h0c, OP_MOV = 5'h0d, OP_REGISTER_PAIR_COPY = 5'h0e, OP_LDI = 5'h0f,
        OP_LD_X = 5'h10, OP_LD_XINC = 5'h11, OP_LD_XDEC = 5'h12,
        OP_IRQ_ON = 5'h13, OP_IRQ_OFF = 5'h14
    } bsm_op_e;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_FETCH = 4'b0010,
        ST_EX1 = 4'b0100,
        ST_EX2 = 4'b1000
    } bsm_state_e;
endpackage

// *** rtl/bsm_if.sv ***
// Interfaces between the execution core and its two memories
`timescale 1ns/1ps
interface bsm_gpr_if;
    logic [4:0] raddr_a;
    logic [4:0] raddr_b;
    logic [7:0] rdata_a;
    logic [7:0] rdata_b;
    logic we;
    logic we_pair;
    logic [4:0] waddr;
    logic [15:0] wdata;
    modport core (output raddr_a, raddr_b, we, we_pair, waddr, wdata, input rdata_a, rdata_b);
    modport mem (input raddr_a, raddr_b, we, we_pair, waddr, wdata, output rdata_a, rdata_b);
endinterface

interface bsm_dm_if;
    logic [7:0] addr;
    logic we;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport core (output addr, we, wdata, input rdata);
    modport mem (input addr, we, wdata, output rdata);
endinterface

// *** rtl/bsm_gpr.sv ***
// Working register file: 32 bytes, two registered read ports, byte or pair write
`timescale 1ns/1ps
module bsm_gpr (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Core side
    bsm_gpr_if.mem gp
);
    import bsm_pkg::*;

    logic [7:0] mem_q [GPR_NUM];
    logic [7:0] rda_q, rda_d, rdb_q, rdb_d;

    // Pair writes land on an even/odd pair, so the upper byte index is fixed
    always_ff @(posedge clk) begin
        if (ce && gp.we) begin
            if (gp.we_pair) begin
                mem_q[{gp.waddr[4:1], 1'b0}] <= gp.wdata[7:0];
                mem_q[{gp.waddr[4:1], 1'b1}] <= gp.wdata[15:8];
            end else begin
                mem_q[gp.waddr] <= gp.wdata[7:0];
            end
        end
    end

    always_comb begin
        rda_d = mem_q[gp.raddr_a];
        rdb_d = mem_q[gp.raddr_b];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rda_q <= 8'h00;
            rdb_q <= 8'h00;
        end else if (ce) begin
            rda_q <= rda_d;
            rdb_q <= rdb_d;
        end
    end

    assign gp.rdata_a = rda_q;
    assign gp.rdata_b = rdb_q;
endmodule

// *** rtl/bsm_dmem.sv ***
// Data memory: 256 bytes, one port, registered read
`timescale 1ns/1ps
module bsm_dmem (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Core side
    bsm_dm_if.mem dm
);
    import bsm_pkg::*;

    logic [7:0] mem_q [DM_DEPTH];
    logic [7:0] rd_q, rd_d;

    always_ff @(posedge clk) begin
        if (ce && dm.we) begin
            mem_q[dm.addr] <= dm.wdata;
        end
    end

    always_comb begin
        rd_d = mem_q[dm.addr];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_q <= 8'h00;
        end else if (ce) begin
            rd_q <= rd_d;
        end
    end

    assign dm.rdata = rd_q;
endmodule

// *** tb/bsm_exec_unit_sva.sv ***
// Assertion checker for the execution unit ports
`timescale 1ns/1ps
module bsm_exec_unit_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bus handshakes
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Execution status
    input wire logic busy,
    input wire logic done
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Fetch, then one or two execute cycles
    sequence one_cyc;
        busy [*2] ##1 !busy;
    endsequence
    sequence two_cyc;
        busy [*3] ##1 !busy;
    endsequence
    AST_BUSY_LEN: assert property ($rose(busy) |-> one_cyc or two_cyc)
        else $error("busy length wrong");
    AST_DONE_END: assert property ($rose(done) |-> $fell(busy))
        else $error("done not at end of run");
    AST_DONE_PULSE: assert property (done |=> !done)
        else $error("done longer than a cycle");
    AST_START: assert property ($rose(busy) |-> s_axi_bvalid)
        else $error("run started without write");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    AST_R_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write taken while response pending");
endmodule

bind bsm_exec_unit bsm_exec_unit_sva chk_i (.clk, .rst, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .busy, .done);

// *** tb/bsm_exec_unit_tb.sv ***
// Self-checking bench for the execution unit
`timescale 1ns/1ps
module bsm_exec_unit_tb;
    import bsm_pkg::*;
    logic clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, busy, done;
    logic [7:0] s_axi_awaddr, s_axi_araddr, v, f, g, m, a, d, e;
    logic [31:0] s_axi_wdata, s_axi_rdata, w;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] x, y;
    logic [2:0] b, c, k;
    logic [4:0] rg;
    bsm_op_e op;
    int mismatches, checks_done, cycles, dones;
    bsm_exec_unit dut (.clk, .rst, .ce(1'b1), .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_bvalid,
        .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .busy, .done);
    always #5 clk = ~clk;
    // Hang guard; a full run needs well under this
    always @(posedge clk) begin
        cycles++;
        dones += done;
        if (cycles == 30000) begin
            mismatches++;
            test_done();
        end
    end
    task test_done;
        if (mismatches == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, exp, input string nm);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // ****************
    // Bus master, ready stalls drawn at random
    // ****************
    task automatic axw(input logic [7:0] ad, input logic [31:0] dt, input logic [1:0] er);
        s_axi_awaddr <= ad;
        s_axi_wdata <= dt;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (!s_axi_bready && $urandom_range(1)) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready));
        chk(s_axi_bresp, er, "bresp");
        s_axi_bready <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] ad, output logic [31:0] dt, input logic [1:0] er);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (!s_axi_rready && $urandom_range(1)) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready));
        dt = s_axi_rdata;
        chk(s_axi_rresp, er, "rresp");
        s_axi_rready <= 1'b0;
    endtask
    task automatic cmp(input logic [7:0] ad, input logic [31:0] ex, input string nm);
        logic [31:0] dt;
        rdr(ad, dt, RESP_OKAY);
        chk(dt, ex, nm);
    endtask
    task automatic run(input bsm_op_e o, input logic [4:0] rd, rr, input logic [2:0] bt);
        int n;
        n = dones;
        axw(OFF_CMD, {5'h0, bt, 3'h0, rr, 3'h0, rd, 3'h0, o}, RESP_OKAY);
        // A slow response may come after the done pulse, so pulses are counted
        do @(posedge clk); while (busy);
        @(posedge clk);
        chk(dones - n, 1, "done");
    endtask
    task automatic immediate_load(input logic [4:0] r, input logic [7:0] val);
        axw(OFF_OPND, {24'h0, val}, RESP_OKAY);
        run(OP_LDI, r, r, 3'h0);
        cmp(OFF_RES, val, "imm");
    endtask
    // Result in the low byte, flags above; S, H, T and I pass through
    function automatic logic [15:0] shx(input bsm_op_e o, input logic [7:0] val, input logic [7:0] fl);
        logic [7:0] r;
        logic cy;
        case (o)
            OP_LSL: {cy, r} = {val, 1'b0};
            OP_LSR: {r, cy} = {1'b0, val};
            OP_ROL: {cy, r} = {val, fl[FLG_C]};
            OP_ROR: {r, cy} = {fl[FLG_C], val};
            OP_ASR: {r, cy} = {val[7], val};
            default: return {fl, val[3:0], val[7:4]};
        endcase
        fl[FLG_C] = cy;
        fl[FLG_Z] = (r == 8'h00);
        fl[FLG_N] = r[7];
        fl[FLG_V] = r[7] ^ cy;
        return {fl, r};
    endfunction
    initial begin
        {clk, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        rst = 1'b1;
        void'($urandom(33));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        cmp(OFF_FLAGS, 32'h0, "flags");
        cmp(OFF_XPTR, 32'h0, "xptr");
        axw(8'h1c, 32'h1, RESP_SLVERR);
        axw(OFF_STAT, 32'h1, RESP_SLVERR);
        rdr(8'h1c, w, RESP_SLVERR);
        chk(w, 32'h0, "unmapped");
        for (int i = 0; i < 40; i++) begin
            op = bsm_op_e'(5'h03 + 5'($urandom_range(5)));
            v = (i < 10) ? {i[0], 6'h0, !i[0]} : 8'($urandom);
            f = $urandom;
            rg = $urandom;
            axw(OFF_FLAGS, {24'h0, f}, RESP_OKAY);
            immediate_load(rg, v);
            run(op, rg, rg, 3'h0);
            y = shx(op, v, f);
            cmp(OFF_RES, y[7:0], "shift result");
            cmp(OFF_STAT, y[15:8], "shift flags");
        end
        for (int i = 0; i < 8; i++) begin
            f = $urandom;
            m = 8'h01 << i;
            axw(OFF_FLAGS, {24'h0, f}, RESP_OKAY);
            run(OP_FLAG_SET, 5'h0, 5'h0, 3'(i));
            cmp(OFF_STAT, f | m, "flag set");
            run(OP_FLAG_CLR, 5'h0, 5'h0, 3'(i));
            cmp(OFF_STAT, f & ~m, "flag clear");
        end
        g = f & 8'h7f;
        run(OP_IRQ_ON, 5'h0, 5'h0, 3'h0);
        cmp(OFF_STAT, g | 8'h80, "irq on");
        run(OP_IRQ_OFF, 5'h0, 5'h0, 3'h0);
        cmp(OFF_STAT, g, "irq off");
        repeat (8) begin
            {v, f, b, c, k} = $urandom;
            immediate_load(5'h5, v);
            axw(OFF_FLAGS, {24'h0, f}, RESP_OKAY);
            run(OP_BST, 5'h5, 5'h5, b);
            g = f;
            g[FLG_T] = v[b];
            cmp(OFF_STAT, g, "transfer out");
            run(OP_BLD, 5'h5, 5'h5, c);
            v[c] = g[FLG_T];
            cmp(OFF_RES, v, "transfer in");
            axw(OFF_IO + {3'h0, k, 2'h0}, {24'h0, v}, RESP_OKAY);
            run(OP_IO_SET, 5'h0, {2'h0, k}, b);
            v[b] = 1'b1;
            cmp(OFF_IO + {3'h0, k, 2'h0}, v, "io set");
            run(OP_IO_CLR, 5'h0, {2'h0, k}, c);
            v[c] = 1'b0;
            cmp(OFF_IO + {3'h0, k, 2'h0}, v, "io clear");
            cmp(OFF_STAT, g, "flags kept");
        end
        {a, d, e} = $urandom;
        immediate_load(5'h2, a);
        immediate_load(5'h3, e);
        run(OP_REGISTER_PAIR_COPY, 5'h8, 5'h2, 3'h0);
        cmp(OFF_RES, a, "pair low");
        run(OP_MOV, 5'ha, 5'h9, 3'h0);
        cmp(OFF_RES, e, "pair high");
        x = $urandom;
        y = x - 16'h1;
        axw(OFF_XPTR, {16'h0, x}, RESP_OKAY);
        axw(OFF_DMWR, {16'h0, x[7:0], d}, RESP_OKAY);
        axw(OFF_DMWR, {16'h0, y[7:0], a}, RESP_OKAY);
        run(OP_LD_XINC, 5'h4, 5'h4, 3'h0);
        cmp(OFF_RES, d, "load inc");
        cmp(OFF_XPTR, x + 16'h1, "x inc");
        run(OP_LD_XDEC, 5'h4, 5'h4, 3'h0);
        run(OP_LD_XDEC, 5'h4, 5'h4, 3'h0);
        cmp(OFF_RES, a, "load dec");
        immediate_load(5'h6, e);
        run(OP_LD_X, 5'h6, 5'h6, 3'h0);
        cmp(OFF_RES, a, "load plain");
        cmp(OFF_XPTR, y, "x dec");
        cmp(OFF_STAT, g, "load flags");
        test_done();
    end
endmodule
